// ### chp_cable_hotplug.sv
// Purpose: cable presence detect, receiver reset and hot-plug drive
// Assumes: inputs synchronous to ref_clk; single register port
// Notes:   the ring-oscillator rate is an enable pulse from a divider
`timescale 1ns/100ps
`default_nettype none
`include "chp_defines.svh"

module chp_cable_hotplug #(
	parameter int RING_DIV    = (`CHP_CLK_KHZ + `CHP_RING_KHZ - 1) / `CHP_RING_KHZ,
	parameter int STEP_CYCLES = `CHP_HPD_STEP_MS * (`CHP_CLK_KHZ)
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	input  wire logic       port_a_supply_sense,
	input  wire logic       edid_enable_a,
	input  wire logic       edid_checksum_done_a,
	input  wire logic       hotplug_out_a_i,
	output logic            hotplug_out_a_o,
	output logic            hotplug_out_a_oe_n,
	output logic            rx_section_reset,
	output logic            cable_plug_event,
	output logic            cable_unplug_event,
	output logic            edid_active_a
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (RING_DIV < 1 || RING_DIV > 255)
		$error("RING_DIV must be 1 to 255");
	if (STEP_CYCLES < 1)
		$error("STEP_CYCLES must be at least 1");

	localparam logic [7:0]  RING_LAST = 8'(RING_DIV - 1);
	localparam logic [31:0] STEP_LAST = 32'(STEP_CYCLES - 1);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_q;
	logic rst_sync_n;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	chp_pkg::chp_state_t q;
	chp_pkg::chp_state_t d;
	logic                filt_w;
	logic                filt_meta_q;

	// ----------------------------------------------------------------
	// deglitch filter
	// ----------------------------------------------------------------
	chp_deglitch u_deglitch (
		.clk        (ref_clk),
		.rst_n      (rst_sync_n),
		.tick       (q.ring_tick),
		.sense      (port_a_supply_sense),
		.time_units (q.dg_time),
		.bypass     (q.dg_off),
		.filtered   (filt_w)
	);

	// filter output comes from the ring domain; resync kept so the path
	// stays correct if that domain is ever split off
	always_ff @(posedge ref_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			filt_meta_q <= 1'b0;
		else
			filt_meta_q <= filt_w;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		d = q;

		// ring-oscillator rate enable
		d.ring_tick = 1'b0;
		if (q.ring_cnt == RING_LAST)
		begin
			d.ring_cnt  = 8'h00;
			d.ring_tick = 1'b1;
		end
		else
			d.ring_cnt = q.ring_cnt + 8'h01;

		// presence sampling and events
		d.raw        = port_a_supply_sense;
		d.filt       = filt_meta_q;
		d.filt_prev  = q.filt;
		d.plug_evt   = q.filt & ~q.filt_prev;
		d.unplug_evt = ~q.filt & q.filt_prev;

		// receiver reset; host clears it when sense is unconnected
		d.rx_rst = ~q.no_rst & ~q.filt;

		// internal edid activation
		if (!edid_enable_a)
			d.edid_act = 1'b0;
		else if (edid_checksum_done_a)
			d.edid_act = 1'b1;

		// assertion delay after plug detection
		case (q.dstate)
			chp_pkg::CHP_DLY_IDLE:
			begin
				d.step_cnt = 32'h0;
				d.steps    = 4'h0;
				if (q.filt)
				begin
					if (q.dly_sel == 4'h0)
						d.dstate = chp_pkg::CHP_DLY_DONE;
					else
						d.dstate = chp_pkg::CHP_DLY_WAIT;
				end
			end
			chp_pkg::CHP_DLY_WAIT:
			begin
				if (!q.filt)
					d.dstate = chp_pkg::CHP_DLY_IDLE;
				else if (q.step_cnt == STEP_LAST)
				begin
					d.step_cnt = 32'h0;
					d.steps    = q.steps + 4'h1;
					if ((q.steps + 4'h1) >= q.dly_sel)
						d.dstate = chp_pkg::CHP_DLY_DONE;
				end
				else
					d.step_cnt = q.step_cnt + 32'h1;
			end
			chp_pkg::CHP_DLY_DONE:
			begin
				if (!q.filt)
					d.dstate = chp_pkg::CHP_DLY_IDLE;
			end
			default:
				d.dstate = chp_pkg::CHP_DLY_IDLE;
		endcase

		// hot-plug level
		if (q.manual)
			d.hotplug_signal = q.man_level;
		else
		begin
			case (q.policy)
				chp_pkg::CHP_POL_EDID:
					d.hotplug_signal = q.edid_act;
				chp_pkg::CHP_POL_DELAYED:
					d.hotplug_signal = (q.dstate == chp_pkg::CHP_DLY_DONE) & q.raw;
				chp_pkg::CHP_POL_EDID_DELAYED:
					d.hotplug_signal = q.edid_act & q.raw
						& (q.dstate == chp_pkg::CHP_DLY_DONE);
				chp_pkg::CHP_POL_EDID_DELAYED_MAN:
					d.hotplug_signal = q.edid_act & q.raw & q.man_level
						& (q.dstate == chp_pkg::CHP_DLY_DONE);
				default:
					d.hotplug_signal = 1'b0;
			endcase
		end

		// register writes
		if (reg_wr)
		begin
			if (hit(reg_addr, `CHP_OFS_MANUAL_LEVEL))
				d.man_level = reg_wdata[`CHP_BIT_MANUAL_LEVEL];
			if (hit(reg_addr, `CHP_OFS_RESET_CTRL))
				d.no_rst = reg_wdata[`CHP_BIT_NO_PLUG_RESET];
			if (hit(reg_addr, `CHP_OFS_DEGLITCH_CFG))
			begin
				d.dg_off  = reg_wdata[`CHP_BIT_DEGLITCH_OFF];
				d.dg_time = reg_wdata[6:0];
			end
			if (hit(reg_addr, `CHP_OFS_POLICY_CFG))
			begin
				d.dly_sel = reg_wdata[7:4];
				d.policy  = chp_pkg::chp_policy_t'(reg_wdata[2:1]);
				d.manual  = reg_wdata[`CHP_BIT_MANUAL_ENABLE];
			end
		end

		// register reads; unmapped offsets and reserved bits read zero
		if (reg_rd)
		begin
			d.rdata = 8'h00;
			if (hit(reg_addr, `CHP_OFS_MANUAL_LEVEL))
				d.rdata[`CHP_BIT_MANUAL_LEVEL] = q.man_level;
			if (hit(reg_addr, `CHP_OFS_RESET_CTRL))
				d.rdata[`CHP_BIT_NO_PLUG_RESET] = q.no_rst;
			if (hit(reg_addr, `CHP_OFS_DEGLITCH_CFG))
				d.rdata = {q.dg_off, q.dg_time};
			if (hit(reg_addr, `CHP_OFS_POLICY_CFG))
				d.rdata = {q.dly_sel, 1'b0, q.policy, q.manual};
			if (hit(reg_addr, `CHP_OFS_PRESENCE_STAT))
				d.rdata = {4'h0, hotplug_out_a_i, q.edid_act, q.filt, q.raw};
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			q           <= '0;
			q.man_level <= `CHP_RST_MANUAL_LEVEL;
			q.no_rst    <= `CHP_RST_NO_PLUG_RESET;
			q.dg_off    <= `CHP_RST_DEGLITCH_OFF;
			q.dg_time   <= `CHP_RST_DEGLITCH_TIME;
			q.dly_sel   <= `CHP_RST_DELAY_SELECT;
			q.policy    <= chp_pkg::chp_policy_t'(`CHP_RST_AUTO_POLICY);
			q.manual    <= `CHP_RST_MANUAL_ENABLE;
			q.dstate    <= chp_pkg::CHP_DLY_IDLE;
			q.rx_rst    <= 1'b1;
		end
		else
			q <= d;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// open drain: output level always low, enable active low
	assign hotplug_out_a_o    = 1'b0;
	assign hotplug_out_a_oe_n = q.hotplug_signal;
	assign rx_section_reset   = q.rx_rst;
	assign cable_plug_event   = q.plug_evt;
	assign cable_unplug_event = q.unplug_evt;
	assign edid_active_a      = q.edid_act;
	assign reg_rdata          = q.rdata;

endmodule

`default_nettype wire

// ### chp_defines.svh
// Purpose: constants of the cable detect / hot-plug control block
// Assumes: included by bare name, definitions only
// Notes:   offsets are register addresses on the register port
`ifndef CHP_DEFINES_SVH
`define CHP_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CHP_OFS_MANUAL_LEVEL   8'h20
`define CHP_OFS_RESET_CTRL     8'h48
`define CHP_OFS_DEGLITCH_CFG   8'h56
`define CHP_OFS_POLICY_CFG     8'h6c
`define CHP_OFS_PRESENCE_STAT  8'h6f

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CHP_BIT_MANUAL_LEVEL   7
`define CHP_BIT_NO_PLUG_RESET  6
`define CHP_BIT_DEGLITCH_OFF   7
`define CHP_BIT_MANUAL_ENABLE  0
`define CHP_RST_MANUAL_LEVEL   1'b1
`define CHP_RST_NO_PLUG_RESET  1'b0
`define CHP_RST_DEGLITCH_OFF   1'b0
`define CHP_RST_DEGLITCH_TIME  7'h58
`define CHP_RST_DELAY_SELECT   4'ha
`define CHP_RST_AUTO_POLICY    2'h1
`define CHP_RST_MANUAL_ENABLE  1'b0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CHP_CLK_KHZ            250000
`define CHP_RING_KHZ           42000
`define CHP_HPD_STEP_MS        100

`endif

// ### chp_pkg.sv
// Purpose: types of the cable detect / hot-plug control block
// Assumes: nothing imported; users write chp_pkg::name
// Notes:   state of the top module is one packed struct, apart from the reset and filter resync flops
package chp_pkg;

	typedef enum logic [1:0] {
		CHP_POL_EDID,
		CHP_POL_DELAYED,
		CHP_POL_EDID_DELAYED,
		CHP_POL_EDID_DELAYED_MAN
	} chp_policy_t;

	typedef enum logic [1:0] {
		CHP_DLY_IDLE,
		CHP_DLY_WAIT,
		CHP_DLY_DONE
	} chp_dly_state_t;

	typedef struct packed {
		logic           man_level;
		logic           no_rst;
		logic           dg_off;
		logic [6:0]     dg_time;
		logic [3:0]     dly_sel;
		chp_policy_t    policy;
		logic           manual;
		logic           raw;
		logic           filt;
		logic           filt_prev;
		logic           plug_evt;
		logic           unplug_evt;
		logic           edid_act;
		chp_dly_state_t dstate;
		logic [31:0]    step_cnt;
		logic [3:0]     steps;
		logic           hotplug_signal;
		logic           rx_rst;
		logic [7:0]     rdata;
		logic [7:0]     ring_cnt;
		logic           ring_tick;
	} chp_state_t;

	typedef struct packed {
		logic       s1;
		logic       s2;
		logic       s3;
		logic [7:0] cnt;
		logic       out;
	} chp_dg_state_t;

endpackage

// ### chp_deglitch.sv
// Purpose: deglitch filter on the supply-sense input
// Assumes: tick is a one-cycle pulse at the ring-oscillator rate
// Notes:   counts in ticks, two ticks per time unit
`timescale 1ns/100ps
`default_nettype none

module chp_deglitch (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       tick,
	input  wire logic       sense,
	input  wire logic [6:0] time_units,
	input  wire logic       bypass,
	output logic            filtered
);

	chp_pkg::chp_dg_state_t q;
	chp_pkg::chp_dg_state_t d;

	// ----------------------------------------------------------------
	// filter
	// ----------------------------------------------------------------
	always_comb
	begin
		d = q;
		if (tick)
		begin
			// s1 feeds only s2; s3 is the history for change detection
			d.s1 = sense;
			d.s2 = q.s1;
			d.s3 = q.s2;
			if (!q.s2 || (q.s2 != q.s3))
			begin
				d.cnt = 8'h00;
				d.out = 1'b0;
			end
			else if (q.cnt >= {time_units, 1'b0})
				d.out = 1'b1;
			else
				d.cnt = q.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	// bypass still sees the synchronised level, never the raw pin
	assign filtered = bypass ? q.s2 : q.out;

endmodule

`default_nettype wire

// ### chp_tx_model.sv
// Purpose: far-side transmitter model: cable supply and pulled-up hot-plug line
// Assumes: hot-plug pin is open drain with a pull-up on the far side
// Notes:   supply sense follows the cable command; no contact bounce
`timescale 1ns/100ps
`default_nettype none

module chp_tx_model (
	input  wire logic cable_in,
	input  wire logic pin_o,
	input  wire logic pin_oe_n,
	output logic      supply_sense,
	output logic      pin
);
	assign supply_sense = cable_in;
	// a released line goes to the pull-up level, never keeps the last value
	assign pin = pin_oe_n ? 1'b1 : pin_o;
endmodule

`default_nettype wire

// ### chp_cable_hotplug_chk.sv
// Purpose: port-level checker of the cable detect / hot-plug block
// Assumes: single clock domain, reset active low
// Notes:   bound to the top module below
`timescale 1ns/100ps
`default_nettype none
`include "chp_defines.svh"

module chp_cable_hotplug_chk (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       port_a_supply_sense,
	input wire logic       edid_enable_a,
	input wire logic       edid_checksum_done_a,
	input wire logic       hotplug_out_a_o,
	input wire logic       hotplug_out_a_oe_n,
	input wire logic       cable_plug_event,
	input wire logic       cable_unplug_event,
	input wire logic       edid_active_a
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	plug_pulse_a: assert property (cable_plug_event |=> !cable_plug_event)
		else $error("plug event longer than one cycle");
	unplug_pulse_a: assert property (cable_unplug_event |=> !cable_unplug_event)
		else $error("unplug event longer than one cycle");
	event_excl_a: assert property (!(cable_plug_event && cable_unplug_event))
		else $error("plug and unplug in one cycle");
	stat_rsvd_a: assert property (reg_rd && reg_addr == `CHP_OFS_PRESENCE_STAT
		|=> reg_rdata[7:4] == 4'h0) else $error("status reserved bits set");
	stat_raw_a: assert property (port_a_supply_sense [*4] ##0 (reg_rd &&
		reg_addr == `CHP_OFS_PRESENCE_STAT) |=> reg_rdata[0]) else $error("raw bit low");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	open_drain_a: assert property (hotplug_out_a_o == 1'b0)
		else $error("hot-plug pin driven high");
	edid_set_a: assert property ($rose(edid_active_a) |->
		$past(edid_enable_a && edid_checksum_done_a)) else $error("edid active without checksum");
	edid_clr_a: assert property (!edid_enable_a |=> !edid_active_a)
		else $error("edid active without enable");
	plug_cause_a: assert property (cable_plug_event |-> $past(port_a_supply_sense, 3))
		else $error("plug event without supply sense");

	cover property (cable_plug_event);
	cover property (cable_unplug_event);
	cover property ($rose(edid_active_a));
	cover property ($fell(hotplug_out_a_oe_n));
endmodule

bind chp_cable_hotplug chp_cable_hotplug_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.port_a_supply_sense(port_a_supply_sense), .edid_enable_a(edid_enable_a),
	.edid_checksum_done_a(edid_checksum_done_a), .hotplug_out_a_o(hotplug_out_a_o),
	.hotplug_out_a_oe_n(hotplug_out_a_oe_n), .cable_plug_event(cable_plug_event),
	.cable_unplug_event(cable_unplug_event), .edid_active_a(edid_active_a));

`default_nettype wire

// ### tb.sv
// Purpose: self-checking bench of the cable detect / hot-plug block
// Assumes: short step and ring divider keep the run small
// Notes:   inputs change on the rising edge, outputs sampled 1 ns later
`timescale 1ns/100ps
`default_nettype none
`include "chp_defines.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("Error t=%0t got %h exp %h", $time, g, e); end end

module tb;
	logic       ref_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       edid_en = 1'b0;
	logic       edid_done = 1'b0;
	logic       cable = 1'b0;
	logic [7:0] rdata;
	logic       sense, pin, pin_o, pin_oe_n, rx_rst, plug_ev, unplug_ev, edid_act;
	int         failures = 0;
	int         n_checks = 0;
	int         cycles = 0;

	always #2 ref_clk = ~ref_clk;

	chp_cable_hotplug #(.RING_DIV(2), .STEP_CYCLES(10)) dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .port_a_supply_sense(sense),
		.edid_enable_a(edid_en), .edid_checksum_done_a(edid_done), .hotplug_out_a_i(pin),
		.hotplug_out_a_o(pin_o), .hotplug_out_a_oe_n(pin_oe_n), .rx_section_reset(rx_rst),
		.cable_plug_event(plug_ev), .cable_unplug_event(unplug_ev), .edid_active_a(edid_act));

	chp_tx_model tx_u (.cable_in(cable), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.supply_sense(sense), .pin(pin));

	task automatic final_report();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// the longest test needs well under 2000 cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			final_report();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask

	function automatic logic obs(input int k);
		return k == 0 ? pin : k == 1 ? rx_rst : k == 2 ? edid_act : k == 3 ? plug_ev : unplug_ev;
	endfunction

	task automatic wt(input int k, input logic e, input int n);
		for (int i = 0; i < n && obs(k) !== e; i++)
			@(posedge ref_clk) #1;
		`CHK(obs(k), e)
	endtask

	task automatic hold(input int k, input logic e, input int n);
		repeat (n)
		begin
			@(posedge ref_clk) #1;
			`CHK(obs(k), e)
		end
	endtask

	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK(rx_rst, 1'b1)
		`CHK(pin, 1'b0)
		rd(`CHP_OFS_MANUAL_LEVEL, 8'h80);
		rd(`CHP_OFS_RESET_CTRL, 8'h00);
		rd(`CHP_OFS_DEGLITCH_CFG, 8'h58);
		rd(`CHP_OFS_POLICY_CFG, 8'ha2);
		wr(`CHP_OFS_PRESENCE_STAT, 8'hff);
		rd(`CHP_OFS_PRESENCE_STAT, 8'h00);
		rd(8'h01, 8'h00);
		$display("test reset values done");

		wr(`CHP_OFS_DEGLITCH_CFG, 8'h04);
		@(posedge ref_clk) cable <= 1'b1;
		repeat (6) @(posedge ref_clk);
		cable <= 1'b0;
		hold(3, 1'b0, 40);
		@(posedge ref_clk) cable <= 1'b1;
		hold(3, 1'b0, 12);
		wt(3, 1'b1, 60);
		wt(1, 1'b0, 4);
		rd(`CHP_OFS_PRESENCE_STAT, 8'h03);
		hold(0, 1'b0, 80);
		wt(0, 1'b1, 40);
		@(posedge ref_clk) cable <= 1'b0;
		wt(0, 1'b0, 4);
		wt(4, 1'b1, 20);
		wt(1, 1'b1, 4);
		$display("test deglitch and delayed plug done");

		wr(`CHP_OFS_RESET_CTRL, 8'h40);
		wt(1, 1'b0, 4);
		wr(`CHP_OFS_RESET_CTRL, 8'h00);
		wt(1, 1'b1, 4);
		wr(`CHP_OFS_DEGLITCH_CFG, 8'hff);
		@(posedge ref_clk) cable <= 1'b1;
		wt(3, 1'b1, 14);
		$display("test reset disable and bypass done");

		wr(`CHP_OFS_POLICY_CFG, 8'h01);
		wt(0, 1'b1, 3);
		wr(`CHP_OFS_MANUAL_LEVEL, 8'h00);
		wt(0, 1'b0, 3);
		wr(`CHP_OFS_POLICY_CFG, 8'h07);
		hold(0, 1'b0, 4);
		wr(`CHP_OFS_MANUAL_LEVEL, 8'h80);
		wt(0, 1'b1, 3);
		rd(`CHP_OFS_PRESENCE_STAT, 8'h0b);
		$display("test manual control done");

		wr(`CHP_OFS_POLICY_CFG, 8'h00);
		@(posedge ref_clk) edid_en <= 1'b1;
		hold(0, 1'b0, 5);
		@(posedge ref_clk) edid_done <= 1'b1;
		@(posedge ref_clk) edid_done <= 1'b0;
		wt(2, 1'b1, 3);
		wt(0, 1'b1, 3);
		wr(`CHP_OFS_POLICY_CFG, 8'h06);
		wr(`CHP_OFS_MANUAL_LEVEL, 8'h00);
		wt(0, 1'b0, 3);
		wr(`CHP_OFS_MANUAL_LEVEL, 8'h80);
		wt(0, 1'b1, 3);
		wr(`CHP_OFS_POLICY_CFG, 8'h04);
		@(posedge ref_clk) cable <= 1'b0;
		wt(0, 1'b0, 4);
		@(posedge ref_clk) cable <= 1'b1;
		wt(0, 1'b1, 20);
		wr(`CHP_OFS_POLICY_CFG, 8'h00);
		@(posedge ref_clk) cable <= 1'b0;
		hold(0, 1'b1, 6);
		@(posedge ref_clk) edid_en <= 1'b0;
		wt(2, 1'b0, 3);
		wt(0, 1'b0, 3);
		$display("test edid policies done");
		final_report();
	end
endmodule

`default_nettype wire
